/* File: logic/rfwp_pkg.sv */
// Purpose: Constants and types for the receive RAM host write port.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Entry is 40 bits, control byte above a 32-bit data word.
package rfwp_pkg;
    localparam int unsigned RFWP_PAW = 12;
    localparam logic [11:0] RFWP_REQ_ADDR_OFF = 12'h070;
    localparam logic [11:0] RFWP_LOW_WORD_OFF = 12'h074;
    localparam int unsigned RFWP_REQ_BIT = 31;
    localparam int unsigned RFWP_ACK_BIT = 30;
    localparam int unsigned RFWP_HI_LSB = 16;
    localparam int unsigned RFWP_HI_MSB = 23;
    localparam int unsigned RFWP_SEL_BIT = 13;
    localparam int unsigned RFWP_RAM_AW = 12;
    localparam int unsigned RFWP_PTR_W = 13;
    localparam int unsigned RFWP_ADX_W = 14;
    localparam int unsigned RFWP_ENTRY_W = 40;
    localparam int unsigned RFWP_SOF_BIT = 35;
    localparam int unsigned RFWP_EOF_BIT = 34;
    localparam int unsigned RFWP_NVLD_MSB = 33;
    localparam int unsigned RFWP_NVLD_LSB = 32;
    localparam logic [7:0] RFWP_HI_RST = 8'h00;
    localparam logic [13:0] RFWP_ADX_RST = 14'h0000;
    localparam logic [31:0] RFWP_LOW_WORD_RST = 32'h00000000;
    typedef enum logic [1:0] {
        RFWP_HS_IDLE,
        RFWP_HS_FIRE,
        RFWP_HS_ACK
    } rfwp_hs_e;
endpackage : rfwp_pkg

/* File: logic/rfwp_apb_if.sv */
// Purpose: APB decode for the two port registers.
// Assumes: Zero wait states; read data is captured in the setup cycle.
// Notes: Unmapped addresses answer with pslverr in the access phase.
module rfwp_apb_if (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rfwp_pkg::RFWP_PAW-1:0] paddr,
    output logic wr_req_addr,
    output logic wr_low_word,
    output logic rd_setup,
    output logic hit_req_addr,
    output logic hit_low_word,
    output logic pready,
    output logic pslverr
);
    import rfwp_pkg::*;

    logic access;
    logic mapped;

    assign hit_req_addr = (paddr == RFWP_REQ_ADDR_OFF);
    assign hit_low_word = (paddr == RFWP_LOW_WORD_OFF);
    assign mapped = hit_req_addr | hit_low_word;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_req_addr = access & pwrite & hit_req_addr;
    assign wr_low_word = access & pwrite & hit_low_word;
    assign rd_setup = psel & ~penable & ~pwrite;

    // Setup cycle never writes or flags an error
    setup_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |-> !wr_req_addr && !wr_low_word && !pslverr)
        else $error("setup cycle wrote or flagged");
endmodule : rfwp_apb_if

/* File: logic/rfwp_handshake.sv */
// Purpose: Four-phase request/acknowledge sequencer for one entry write.
// Assumes: Request comes from a register on the same clock.
// Notes: One fire pulse per request rise, then acknowledge until release.
module rfwp_handshake (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    output logic fire,
    output logic ack
);
    import rfwp_pkg::*;

    rfwp_hs_e state_q;
    rfwp_hs_e state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RFWP_HS_IDLE: begin
                if (req) begin
                    state_d = RFWP_HS_FIRE;
                end
            end
            RFWP_HS_FIRE: begin
                state_d = RFWP_HS_ACK;
            end
            RFWP_HS_ACK: begin
                if (!req) begin
                    state_d = RFWP_HS_IDLE;
                end
            end
            default: begin
                state_d = RFWP_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RFWP_HS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign fire = (state_q == RFWP_HS_FIRE);
    assign ack = (state_q == RFWP_HS_ACK);
endmodule : rfwp_handshake

/* File: logic/rfwp_top.sv */
// Purpose: Host port that writes receive FIFO RAM entries or loads the
//          receive FIFO write pointer under a request/acknowledge handshake.
// Assumes: Receive FIFO logic runs on pclk; write pointer input is synchronous.
// Notes: Registers reached over APB; one RAM or pointer write per request.
//
// Overview of operation
// - Acknowledge follows request rise and fall only
// - Acknowledge means entry or pointer was accepted
// - Reserved bits ignore writes, read as zero
// - Upper entry byte held in bits 23:16
// - Upper byte: start, end, valid byte count
// - RAM written only with select clear, request set
// - Address field reads back live write pointer
// - Address write loads staged address register
// - Select low: bits 11:0 address the RAM
// - Select high: bits 12:0 load write pointer
// - Field sized for 13-bit pointer, select above
// - Second register holds lower four entry bytes
//
// Our own choices: the placing of the registers and the APB register port.
module rfwp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rfwp_pkg::RFWP_PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [rfwp_pkg::RFWP_PTR_W-1:0] rx_wr_ptr,
    output logic ram_wr_en,
    output logic [rfwp_pkg::RFWP_RAM_AW-1:0] ram_wr_addr,
    output logic [rfwp_pkg::RFWP_ENTRY_W-1:0] ram_wr_data,
    output logic ptr_load,
    output logic [rfwp_pkg::RFWP_PTR_W-1:0] ptr_value
);
    import rfwp_pkg::*;

    logic wr_req_addr;
    logic wr_low_word;
    logic rd_setup;
    logic hit_req_addr;
    logic hit_low_word;
    logic fire;
    logic ack;
    logic req_q;
    logic [7:0] hi_q;
    logic [RFWP_ADX_W-1:0] adx_q;
    logic [31:0] adx_merge;
    logic [31:0] lo_q;
    logic [31:0] prdata_q;
    logic [31:0] req_addr_view;
    logic [31:0] rd_mux;
    logic sel;

    rfwp_apb_if u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_req_addr(wr_req_addr),
        .wr_low_word(wr_low_word),
        .rd_setup(rd_setup),
        .hit_req_addr(hit_req_addr),
        .hit_low_word(hit_low_word),
        .pready(pready),
        .pslverr(pslverr)
    );

    rfwp_handshake u_hs (
        .pclk(pclk),
        .presetn(presetn),
        .req(req_q),
        .fire(fire),
        .ack(ack)
    );

    // Byte-lane merge for APB write strobes
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Request bit is software owned; hardware never clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 1'b0;
        end else if (wr_req_addr && pstrb[3]) begin
            req_q <= pwdata[RFWP_REQ_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= RFWP_HI_RST;
        end else if (wr_req_addr && pstrb[2]) begin
            hi_q <= pwdata[RFWP_HI_MSB:RFWP_HI_LSB];
        end
    end

    // Staged address keeps select bit 13 above the 13-bit pointer field
    assign adx_merge = lane_merge({18'h00000, adx_q}, pwdata, pstrb);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adx_q <= RFWP_ADX_RST;
        end else if (wr_req_addr) begin
            adx_q <= adx_merge[RFWP_ADX_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_q <= RFWP_LOW_WORD_RST;
        end else if (wr_low_word) begin
            lo_q <= lane_merge(lo_q, pwdata, pstrb);
        end
    end

    // Readback: reserved ranges forced to zero, address shows live pointer
    always_comb begin
        req_addr_view = 32'h00000000;
        req_addr_view[RFWP_REQ_BIT] = req_q;
        req_addr_view[RFWP_ACK_BIT] = ack;
        req_addr_view[RFWP_HI_MSB:RFWP_HI_LSB] = hi_q;
        req_addr_view[RFWP_PTR_W-1:0] = rx_wr_ptr;
    end

    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_req_addr) begin
            rd_mux = req_addr_view;
        end else if (hit_low_word) begin
            rd_mux = lo_q;
        end
    end

    // Read data captured in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata = prdata_q;

    // Entry and pointer paths; fire lasts exactly one cycle per request
    assign sel = adx_q[RFWP_SEL_BIT];
    assign ram_wr_en = fire & ~sel;
    assign ram_wr_addr = adx_q[RFWP_RAM_AW-1:0];
    assign ram_wr_data = {hi_q, lo_q};
    assign ptr_load = fire & sel;
    assign ptr_value = adx_q[RFWP_PTR_W-1:0];

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic apb_wr_hit;
    logic apb_rd_acc;
    assign apb_wr_hit = psel && penable && pwrite && pready;
    assign apb_rd_acc = psel && penable && !pwrite && pready;

    // Strobes seen while the current request is held
    logic [1:0] wr_seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_seen_q <= 2'h0;
        end else if (!req_q) begin
            wr_seen_q <= 2'h0;
        end else if ((ram_wr_en || ptr_load) && !wr_seen_q[1]) begin
            wr_seen_q <= wr_seen_q + 2'h1;
        end
    end

    sequence s_req_rise;
        $rose(req_q) && !ack;
    endsequence

    sequence s_fire_then_ack;
        fire ##1 (ack && !fire);
    endsequence

    sequence s_req_release;
        $fell(req_q) && ack;
    endsequence

    // Request rise leads to one write then acknowledge
    ack_after_req_a: assert property (
        s_req_rise |=> s_fire_then_ack
    ) else $error("ack did not follow request rise");

    // Acknowledge drops the cycle after request release
    ack_release_a: assert property (
        s_req_release |=> !ack
    ) else $error("ack did not drop after request fell");

    // Acknowledge never rises without a live request
    ack_cause_a: assert property (
        $rose(ack) |-> req_q && $past(fire)
    ) else $error("ack rose without request");

    // Acknowledge never falls while request is held
    ack_hold_a: assert property (
        $fell(ack) |-> !$past(req_q)
    ) else $error("ack fell while request held");

    // No second write strobe in the cycle after a strobe, with request still held
    one_write_a: assert property (
        (ram_wr_en || ptr_load) |=> !(ram_wr_en || ptr_load) throughout (req_q [*1])
    ) else $error("more than one write per request");

    // RAM write only with select clear and request live
    ram_gate_a: assert property (
        ram_wr_en |-> !adx_q[RFWP_SEL_BIT] && req_q && !ack
    ) else $error("RAM write outside its conditions");

    // Pointer load only with select set, never together with RAM write
    ptr_gate_a: assert property (
        ptr_load |-> adx_q[RFWP_SEL_BIT] && !ram_wr_en
                     && ptr_value == adx_q[12:0]
    ) else $error("pointer load outside its conditions");

    // Control byte positions inside the entry
    entry_layout_a: assert property (
        ram_wr_en |-> ram_wr_data[RFWP_SOF_BIT] == hi_q[3]
                      && ram_wr_data[RFWP_EOF_BIT] == hi_q[2]
                      && ram_wr_data[RFWP_NVLD_MSB:RFWP_NVLD_LSB] == hi_q[1:0]
                      && ram_wr_data[31:0] == lo_q
    ) else $error("entry layout wrong");

    // Reserved ranges read as zero
    reserved_zero_a: assert property (
        (apb_rd_acc && hit_req_addr) |-> prdata[29:24] == 6'h00
                                         && prdata[15:13] == 3'h0
    ) else $error("reserved bits not zero");

    // Address field reads back the live write pointer
    ptr_readback_a: assert property (
        (rd_setup && hit_req_addr) |=> prdata[12:0] == $past(rx_wr_ptr)
    ) else $error("address readback not the write pointer");

    // Upper byte written through lane 2
    hi_write_a: assert property (
        (apb_wr_hit && hit_req_addr && pstrb[2]) |=> hi_q == $past(pwdata[23:16])
    ) else $error("upper byte not stored");

    // Staged address loaded with select at bit 13
    adx_write_a: assert property (
        (apb_wr_hit && hit_req_addr && pstrb[1:0] == 2'h3)
            |=> adx_q == $past(pwdata[13:0])
    ) else $error("staged address not loaded");

    // Lower word written on a full-strobe write
    lo_write_a: assert property (
        (apb_wr_hit && hit_low_word && pstrb == 4'hF) |=> lo_q == $past(pwdata)
    ) else $error("lower word not stored");

    // Writes to the low word never disturb the staged upper byte
    lo_isolated_a: assert property (
        (apb_wr_hit && hit_low_word) |=> $stable(hi_q) && $stable(adx_q)
    ) else $error("low word write touched other fields");

    // Zero-wait answer in the access phase
    apb_ready_a: assert property (
        (psel && !penable) ##1 (psel && penable) |-> pready
    ) else $error("access phase not answered");

    // Unmapped address flagged
    apb_err_a: assert property (
        (psel && penable && !hit_req_addr && !hit_low_word) |-> pslverr
    ) else $error("unmapped address not flagged");

    // Fire never starts while acknowledge is still up
    fire_idle_a: assert property (
        $rose(fire) |-> !$past(ack) && $past(req_q)
    ) else $error("write started from a busy handshake");

    // At most one strobe while a request is held
    wr_count_a: assert property (
        !wr_seen_q[1]
    ) else $error("second write within one request");

    // RAM write and pointer load never together
    strobe_excl_a: assert property (
        !(ram_wr_en && ptr_load)
    ) else $error("RAM write and pointer load together");

    // Acknowledge follows the strobe at once
    strobe_ack_a: assert property (
        (ram_wr_en || ptr_load) |=> ack
    ) else $error("ack missing after write strobe");

    // Acknowledge held while request is held
    ack_stay_a: assert property (
        (ack && req_q) |=> ack
    ) else $error("ack dropped while request held");

    // Request bit taken through lane 3
    req_write_a: assert property (
        (apb_wr_hit && hit_req_addr && pstrb[3]) |=> req_q == $past(pwdata[31])
    ) else $error("request bit not stored");

    // Upper byte untouched when lane 2 is off
    hi_lane_a: assert property (
        (apb_wr_hit && hit_req_addr && !pstrb[2]) |=> $stable(hi_q)
    ) else $error("upper byte changed without its lane");

    // Staged address untouched when its lanes are off
    adx_lane_a: assert property (
        (apb_wr_hit && hit_req_addr && pstrb[1:0] == 2'h0) |=> $stable(adx_q)
    ) else $error("staged address changed without its lanes");

    // Unmapped writes change no register
    miss_write_a: assert property (
        (apb_wr_hit && !hit_req_addr && !hit_low_word)
            |=> $stable(req_q) && $stable(hi_q) && $stable(adx_q) && $stable(lo_q)
    ) else $error("unmapped write changed a register");

    // Lower word reads back as stored
    lo_readback_a: assert property (
        (rd_setup && hit_low_word) |=> prdata == $past(lo_q)
    ) else $error("lower word readback wrong");

    // Request, acknowledge and upper byte read back
    status_readback_a: assert property (
        (rd_setup && hit_req_addr) |=> prdata[31] == $past(req_q)
            && prdata[30] == $past(ack) && prdata[23:16] == $past(hi_q)
    ) else $error("request register readback wrong");

    // Unmapped reads return zero
    miss_read_a: assert property (
        (rd_setup && !hit_req_addr && !hit_low_word) |=> prdata == 32'h00000000
    ) else $error("unmapped read not zero");

    // Read data holds between read setups
    prdata_hold_a: assert property (
        !rd_setup |=> $stable(prdata)
    ) else $error("read data changed outside a read");

    // Mapped accesses never flag an error
    err_mapped_a: assert property (
        (psel && penable && (hit_req_addr || hit_low_word)) |-> !pslverr
    ) else $error("mapped access flagged");

endmodule : rfwp_top

/* File: tb/tb_rx_fifo_ram_host_write_port.sv */
// Purpose: Self-checking bench for the receive RAM host write port.
// Assumes: Zero-wait APB slave; one RAM or pointer strobe per request rise.
// Notes: Expected strobes and reads are queued; a monitor checks them.
module tb_rx_fifo_ram_host_write_port;
    timeunit 1ns;
    timeprecision 1ps;
    import rfwp_pkg::*;

    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [RFWP_PAW-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [RFWP_PTR_W-1:0] rx_wr_ptr;
    logic ram_wr_en;
    logic [RFWP_RAM_AW-1:0] ram_wr_addr;
    logic [RFWP_ENTRY_W-1:0] ram_wr_data;
    logic ptr_load;
    logic [RFWP_PTR_W-1:0] ptr_value;
    int num_errors = 0;
    int cmp_count = 0;
    integer seed = 49;
    logic [63:0] exp_wr_q[$];
    logic [32:0] exp_rd_q[$];

    always #20 pclk = ~pclk;

    rfwp_top dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_wr_ptr(rx_wr_ptr),
        .ram_wr_en(ram_wr_en),
        .ram_wr_addr(ram_wr_addr),
        .ram_wr_data(ram_wr_data),
        .ptr_load(ptr_load),
        .ptr_value(ptr_value)
    );

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer, then one idle edge so no signal is driven twice a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(pready, 64'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd_q.push_back(e);
        apb(1'b0, a, 32'h00000000, 4'h0);
    endtask : rd

    // Monitor: compares each completed read and each write strobe
    always @(posedge pclk) begin
        if (presetn === 1'b1 && psel && penable && !pwrite && pready) begin
            if (exp_rd_q.size() == 0) begin
                check({pslverr, prdata}, 64'hFFFFFFFFFFFFFFFF);
            end else begin
                check({pslverr, prdata}, exp_rd_q.pop_front());
            end
        end
        if (ram_wr_en !== 1'b0 || ptr_load !== 1'b0) begin
            if (exp_wr_q.size() == 0) begin
                check({ram_wr_en, ptr_load}, 64'hFFFFFFFFFFFFFFFF);
            end else if (ram_wr_en === 1'b1) begin
                check({ram_wr_en, ptr_load, 10'h000, ram_wr_addr, ram_wr_data},
                      exp_wr_q.pop_front());
            end else begin
                check({ram_wr_en, ptr_load, 49'h0, ptr_value}, exp_wr_q.pop_front());
            end
        end
    end

    initial begin
        #(4000 * 40);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] lo;
        logic [7:0] hi;
        logic [13:0] adx;
        logic [5:0] junk;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        rx_wr_ptr = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rx_wr_ptr <= 13'($random(seed));
        @(posedge pclk);
        check({ram_wr_en, ptr_load, ram_wr_addr, ptr_value}, 64'h0);
        check(ram_wr_data, 64'h0);
        rd(RFWP_REQ_ADDR_OFF, {9'h000, 8'h00, 3'h0, rx_wr_ptr});
        rd(RFWP_LOW_WORD_OFF, 33'h0);
        for (int i = 0; i < 6; i++) begin
            lo = $random(seed);
            hi = 8'($random(seed));
            adx = 14'($random(seed));
            adx[13] = i[0];
            junk = 6'($random(seed));
            rx_wr_ptr <= 13'($random(seed));
            wr(RFWP_LOW_WORD_OFF, lo, 4'hF);
            if (adx[13]) begin
                exp_wr_q.push_back({2'b01, 49'h0, adx[12:0]});
            end else begin
                exp_wr_q.push_back({2'b10, 10'h000, adx[11:0], hi, lo});
            end
            // Ack and bits 15:14 written high, random reserved bits 29:24, must be ignored
            wr(RFWP_REQ_ADDR_OFF, {2'b11, junk, hi, 2'b11, adx}, 4'hF);
            repeat (2) @(posedge pclk);
            rd(RFWP_REQ_ADDR_OFF, {3'b011, 6'h00, hi, 3'h0, rx_wr_ptr});
            rd(RFWP_LOW_WORD_OFF, {1'b0, lo});
            wr(RFWP_REQ_ADDR_OFF, {8'h00, hi, 2'b00, adx}, 4'hF);
            repeat (2) @(posedge pclk);
            rd(RFWP_REQ_ADDR_OFF, {3'b000, 6'h00, hi, 3'h0, rx_wr_ptr});
        end
        wr(RFWP_LOW_WORD_OFF, 32'hA5A5A5A5, 4'b0101);
        rd(RFWP_LOW_WORD_OFF, {1'b0, lo[31:24], 8'hA5, lo[15:8], 8'hA5});
        wr(RFWP_REQ_ADDR_OFF, 32'hFFFFFFFF, 4'b0100);
        rd(RFWP_REQ_ADDR_OFF, {3'b000, 6'h00, 8'hFF, 3'h0, rx_wr_ptr});
        wr(12'h078, $random(seed), 4'hF);
        rd(12'h078, {1'b1, 32'h0});
        rd(RFWP_LOW_WORD_OFF, {1'b0, lo[31:24], 8'hA5, lo[15:8], 8'hA5});
        repeat (4) @(posedge pclk);
        check(exp_wr_q.size() + exp_rd_q.size(), 64'h0);
        report_and_stop();
    end
endmodule : tb_rx_fifo_ram_host_write_port
